// >>> verilog/tsg_unit.sv
`timescale 1ns/1ps
module tsg_unit
   import tsg_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   mode_64,
   input  wire logic [63:0]            tss_base,
   input  wire logic [31:0]            tss_limit,
   input  wire logic                   cmd_load16,
   input  wire logic                   cmd_save16,
   input  wire logic                   cmd_fetch64,
   input  wire logic [31:0]            ip_in,
   input  wire logic [31:0]            flags_in,
   input  wire logic [GPR_CNT-1:0][31:0] gpr_in,
   input  wire logic                   xfer_req,
   input  wire logic                   xfer_to_task,
   input  wire logic                   interrupt_return_op_req,
   input  wire logic                   nested_task_flag,
   output logic                        mem_req,
   output logic                        mem_we,
   output logic                        mem_wide,
   output logic      [63:0]            mem_addr,
   output logic      [31:0]            mem_wdata,
   input  wire logic [31:0]            mem_rdata,
   input  wire logic                   mem_ack,
   output logic                        busy,
   output logic                        done,
   output logic                        limit_fault,
   output logic                        protection_fault,
   output logic                        xfer_ok,
   output logic                        keep_paging,
   output logic                        io_map_valid,
   output logic      [15:0]            io_map_offset,
   output logic      [15:0]            link_out,
   output logic      [5:0][15:0]       ring_stack_out,
   output logic      [31:0]            ip_out,
   output logic      [31:0]            flags_out,
   output logic      [GPR_CNT-1:0][31:0] gpr_out,
   output logic      [3:0][15:0]       seg_sel_out,
   output logic      [15:0]            ldt_sel_out,
   output logic      [RSP_CNT-1:0][63:0] privilege_stack_pointers,
   output logic      [IST_CNT-1:0][63:0] interrupt_stack_pointers
);

   typedef struct packed {
      tsg_state_t                         st;
      logic [4:0]                         idx;
      logic                               fmt64;
      logic                               done;
      logic                               limit_fault;
      logic                               keep_paging;
      logic                               io_map_valid;
      logic [31:0]                        wdata;
      logic [TS16_WORDS-1:0][15:0]        w16;
      logic [TS64_DWORDS-1:0][31:0]       d64;
   } tsg_unit_t;

   tsg_unit_t  s_r;
   tsg_unit_t  s_nxt;
   logic       ts16_ok;

   tsg_addr u_addr (
      .fmt64  (s_r.fmt64),
      .idx    (s_r.idx),
      .base   (tss_base),
      .offset (),
      .addr   (mem_addr)
   );

   tsg_fault u_fault (
      .clk              (clk),
      .rst              (rst),
      .mode_64          (mode_64),
      .xfer_req         (xfer_req),
      .xfer_to_task     (xfer_to_task),
      .interrupt_return_op_req         (interrupt_return_op_req),
      .nested_task_flag (nested_task_flag),
      .protection_fault (protection_fault),
      .xfer_ok          (xfer_ok)
   );

   assign ts16_ok = (tss_limit >= TS16_MIN_LIMIT);

   // words are picked one cycle early so the write data stands steady
   function automatic logic [15:0] save_word(input logic [4:0] i);
      logic [2:0] g;
      g = 3'(i - TS16_GPR_IDX);
      // upper halves never reach memory
      if (i == TS16_IP_IDX)
      begin
         return ip_in[15:0];
      end
      else if (i == TS16_FLAGS_IDX)
      begin
         return flags_in[15:0];
      end
      else
      begin
         return gpr_in[g][15:0];
      end
   endfunction : save_word

   always_comb
   begin
      s_nxt             = s_r;
      s_nxt.done        = 1'b0;
      s_nxt.limit_fault = 1'b0;
      unique case (s_r.st)
         TSG_IDLE:
         begin
            // hardware task state in 64-bit mode is refused, so 16-bit
            // commands are dropped there
            if (cmd_fetch64 && mode_64)
            begin
               s_nxt.st    = TSG_FETCH64;
               s_nxt.fmt64 = 1'b1;
               s_nxt.idx   = 5'h00;
            end
            else if ((cmd_load16 || cmd_save16) && !mode_64)
            begin
               if (!ts16_ok)
               begin
                  s_nxt.limit_fault = 1'b1;
               end
               else if (cmd_load16)
               begin
                  s_nxt.st    = TSG_LOAD16;
                  s_nxt.fmt64 = 1'b0;
                  s_nxt.idx   = 5'h00;
               end
               else
               begin
                  s_nxt.st    = TSG_SAVE16;
                  s_nxt.fmt64 = 1'b0;
                  s_nxt.idx   = TS16_IP_IDX;
               end
            end
         end
         TSG_LOAD16:
         begin
            if (mem_ack)
            begin
               s_nxt.w16[s_r.idx] = mem_rdata[15:0];
               if (s_r.idx == TS16_LAST_IDX)
               begin
                  s_nxt.st           = TSG_IDLE;
                  s_nxt.done         = 1'b1;
                  s_nxt.keep_paging  = 1'b1;
                  s_nxt.io_map_valid = 1'b0;
                  s_nxt.d64[TS64_IOMAP_IDX] = 32'h00000000;
               end
               else
               begin
                  s_nxt.idx = s_r.idx + 5'h01;
               end
            end
         end
         TSG_SAVE16:
         begin
            if (mem_ack)
            begin
               s_nxt.w16[s_r.idx] = s_r.wdata[15:0];
               if (s_r.idx == TS16_GPR_LAST)
               begin
                  s_nxt.st   = TSG_IDLE;
                  s_nxt.done = 1'b1;
               end
               else
               begin
                  s_nxt.idx = s_r.idx + 5'h01;
               end
            end
         end
         TSG_FETCH64:
         begin
            if (mem_ack)
            begin
               s_nxt.d64[s_r.idx] = mem_rdata;
               if (s_r.idx == TS64_LAST_IDX)
               begin
                  s_nxt.st           = TSG_IDLE;
                  s_nxt.done         = 1'b1;
                  s_nxt.keep_paging  = 1'b0;
                  s_nxt.io_map_valid = 1'b1;
               end
               else
               begin
                  s_nxt.idx = s_r.idx + 5'h01;
               end
            end
         end
         // three state bits leave four codes unused
         default:
         begin
            s_nxt.st = TSG_IDLE;
         end
      endcase
      if (s_nxt.st == TSG_SAVE16)
      begin
         s_nxt.wdata = {16'h0000, save_word(s_nxt.idx)};
      end
      else
      begin
         s_nxt.wdata = 32'h00000000;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign busy        = (s_r.st != TSG_IDLE);
   assign mem_req     = busy;
   assign mem_we      = (s_r.st == TSG_SAVE16);
   assign mem_wide    = s_r.fmt64;
   assign mem_wdata   = s_r.wdata;
   assign done        = s_r.done;
   assign limit_fault = s_r.limit_fault;
   assign keep_paging = s_r.keep_paging;
   assign io_map_valid = s_r.io_map_valid;
   // offset sits in the upper half of the dword at the map base location
   assign io_map_offset = s_r.d64[TS64_IOMAP_IDX][31:16];

   assign link_out    = s_r.w16[0];
   assign ip_out      = {16'h0000, s_r.w16[TS16_IP_IDX]};
   assign flags_out   = {16'h0000, s_r.w16[TS16_FLAGS_IDX]};
   assign ldt_sel_out = s_r.w16[TS16_LDT_IDX];

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_stk
         assign ring_stack_out[gi] = s_r.w16[TS16_STK_IDX + gi];
      end
      for (gi = 0; gi < GPR_CNT; gi++)
      begin : g_gpr
         // upper halves come back as zero, not the old contents
         assign gpr_out[gi] = {16'h0000, s_r.w16[TS16_GPR_IDX + gi]};
      end
      for (gi = 0; gi < 4; gi++)
      begin : g_sel
         assign seg_sel_out[gi] = s_r.w16[TS16_SEL_IDX + gi];
      end
      for (gi = 0; gi < RSP_CNT; gi++)
      begin : g_rsp
         assign privilege_stack_pointers[gi] =
            {s_r.d64[2*gi+1], s_r.d64[2*gi]};
      end
      for (gi = 0; gi < IST_CNT; gi++)
      begin : g_ist
         assign interrupt_stack_pointers[gi] =
            {s_r.d64[6+2*gi+1], s_r.d64[6+2*gi]};
      end
   endgenerate

endmodule : tsg_unit

// >>> verilog/tsg_pkg.sv
package tsg_pkg;

   localparam logic [31:0] TS16_MIN_LIMIT = 32'h0000002c;
   localparam int          TS16_WORDS     = 22;
   localparam logic [4:0]  TS16_LAST_IDX  = 5'h15;
   localparam logic [4:0]  TS16_IP_IDX    = 5'h07;
   localparam logic [4:0]  TS16_FLAGS_IDX = 5'h08;
   localparam logic [4:0]  TS16_GPR_IDX   = 5'h09;
   localparam logic [4:0]  TS16_GPR_LAST  = 5'h10;
   localparam int          TS16_STK_IDX   = 1;
   localparam int          TS16_SEL_IDX   = 17;
   localparam int          TS16_LDT_IDX   = 21;
   localparam int          GPR_CNT        = 8;

   localparam int          TS64_DWORDS    = 21;
   localparam logic [4:0]  TS64_LAST_IDX  = 5'h14;
   localparam logic [4:0]  TS64_IST_IDX   = 5'h06;
   localparam logic [4:0]  TS64_IOMAP_IDX = 5'h14;
   localparam logic [6:0]  TS64_RSP_OFS   = 7'h04;
   localparam logic [6:0]  TS64_IST_OFS   = 7'h24;
   localparam logic [6:0]  TS64_IOMAP_OFS = 7'h64;
   localparam int          RSP_CNT        = 3;
   localparam int          IST_CNT        = 7;

   typedef enum logic [2:0] {
      TSG_IDLE,
      TSG_LOAD16,
      TSG_SAVE16,
      TSG_FETCH64
   } tsg_state_t;

endpackage : tsg_pkg

// >>> verilog/tsg_addr.sv
`timescale 1ns/1ps
module tsg_addr
   import tsg_pkg::*;
(
   input  wire logic        fmt64,
   input  wire logic [4:0]  idx,
   input  wire logic [63:0] base,
   output logic      [6:0]  offset,
   output logic      [63:0] addr
);

   logic [4:0] rel;

   always_comb
   begin
      rel = idx - TS64_IST_IDX;
      if (!fmt64)
      begin
         offset = {1'b0, idx, 1'b0};
      end
      else if (idx == TS64_IOMAP_IDX)
      begin
         offset = TS64_IOMAP_OFS;
      end
      else if (idx >= TS64_IST_IDX)
      begin
         // skips the reserved quadword between the two pointer groups
         offset = 7'(TS64_IST_OFS + {rel, 2'h0});
      end
      else
      begin
         offset = 7'(TS64_RSP_OFS + {idx, 2'h0});
      end
      addr = base + {57'h0, offset};
   end

endmodule : tsg_addr

// >>> verilog/tsg_fault.sv
`timescale 1ns/1ps
module tsg_fault
   import tsg_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic mode_64,
   input  wire logic xfer_req,
   input  wire logic xfer_to_task,
   input  wire logic interrupt_return_op_req,
   input  wire logic nested_task_flag,
   output logic      protection_fault,
   output logic      xfer_ok
);

   typedef struct packed {
      logic fault;
      logic ok;
   } tsg_fault_t;

   tsg_fault_t s_r;
   tsg_fault_t s_nxt;

   always_comb
   begin
      s_nxt       = '0;
      // jump, call, software or hardware interrupt all look alike here
      if (xfer_req && mode_64 && xfer_to_task)
      begin
         s_nxt.fault = 1'b1;
      end
      else if (interrupt_return_op_req && mode_64 && nested_task_flag)
      begin
         s_nxt.fault = 1'b1;
      end
      else if (xfer_req || interrupt_return_op_req)
      begin
         s_nxt.ok = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign protection_fault = s_r.fault;
   assign xfer_ok          = s_r.ok;

endmodule : tsg_fault

// >>> tb/tsg_monitor.sv
`timescale 1ns/1ps
module tsg_monitor
   import tsg_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        mode_64,
   input wire logic [63:0] tss_base,
   input wire logic [31:0] tss_limit,
   input wire logic        cmd_load16,
   input wire logic        xfer_req,
   input wire logic        xfer_to_task,
   input wire logic        interrupt_return_op_req,
   input wire logic        nested_task_flag,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic        mem_wide,
   input wire logic [63:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        limit_fault,
   input wire logic        protection_fault,
   input wire logic        xfer_ok,
   input wire logic        keep_paging,
   input wire logic        io_map_valid
);
   logic [63:0] ofs;
   assign ofs = mem_addr - tss_base;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_task_xfer;
      xfer_req && mode_64 && xfer_to_task;
   endsequence
   sequence s_short_cmd;
      cmd_load16 && !busy && !mode_64 && tss_limit < 32'h0000002c;
   endsequence
   property p_xfer_fault;
      s_task_xfer |=> protection_fault;
   endproperty
   a_xfer_fault: assert property (p_xfer_fault) else $error("task transfer not refused");
   property p_interrupt_return_op_fault;
      interrupt_return_op_req && mode_64 && nested_task_flag |=> protection_fault && !xfer_ok;
   endproperty
   a_interrupt_return_op_fault: assert property (p_interrupt_return_op_fault) else $error("nested return not refused");
   property p_legacy_ok;
      (xfer_req || interrupt_return_op_req) && !mode_64 |=> xfer_ok && !protection_fault;
   endproperty
   a_legacy_ok: assert property (p_legacy_ok) else $error("legacy transfer refused");
   property p_limit;
      s_short_cmd |=> limit_fault && !mem_req ##1 !mem_req;
   endproperty
   a_limit: assert property (p_limit) else $error("short limit not faulted");
   property p_keep_paging;
      $rose(keep_paging) |-> done;
   endproperty
   a_keep_paging: assert property (p_keep_paging) else $error("paging kept off done");
   property p_no_iomap16;
      $fell(io_map_valid) |-> done && keep_paging;
   endproperty
   a_no_iomap16: assert property (p_no_iomap16) else $error("io map drop unexpected");
   property p_save_low;
      mem_req && mem_we |-> !mem_wide && mem_wdata[31:16] == 16'h0000
         && ofs >= 64'h000000000000000e && ofs <= 64'h0000000000000020;
   endproperty
   a_save_low: assert property (p_save_low) else $error("upper half written");
   property p_ofs16;
      mem_req && !mem_wide |-> ofs <= 64'h000000000000002a && !ofs[0];
   endproperty
   a_ofs16: assert property (p_ofs16) else $error("16-bit offset out of layout");
   property p_ofs64;
      mem_req && mem_wide |-> ofs <= 64'h0000000000000064 && ofs[1:0] == 2'h0;
   endproperty
   a_ofs64: assert property (p_ofs64) else $error("64-bit offset out of layout");
   property p_resv;
      mem_req && mem_wide |-> !(ofs inside {64'h0, 64'h1c, 64'h20, 64'h5c, 64'h60});
   endproperty
   a_resv: assert property (p_resv) else $error("reserved field touched");
endmodule : tsg_monitor

bind tsg_unit tsg_monitor tsg_monitor_i (.clk(clk), .rst(rst), .mode_64(mode_64),
   .tss_base(tss_base), .tss_limit(tss_limit), .cmd_load16(cmd_load16), .xfer_req(xfer_req),
   .xfer_to_task(xfer_to_task), .interrupt_return_op_req(interrupt_return_op_req), .nested_task_flag(nested_task_flag),
   .mem_req(mem_req), .mem_we(mem_we), .mem_wide(mem_wide), .mem_addr(mem_addr),
   .mem_wdata(mem_wdata), .busy(busy), .done(done), .limit_fault(limit_fault),
   .protection_fault(protection_fault), .xfer_ok(xfer_ok), .keep_paging(keep_paging),
   .io_map_valid(io_map_valid));

// >>> tb/test_task_state_segment_handling.sv
`timescale 1ns/1ps
module test_task_state_segment_handling;
   import tsg_pkg::*;
   localparam logic [63:0] B = 64'h0000000000012000;
   logic clk = 1'b0, rst = 1'b1, mode_64 = 1'b0, cmd_load16 = 1'b0, cmd_save16 = 1'b0;
   logic cmd_fetch64 = 1'b0, xfer_req = 1'b0, xfer_to_task = 1'b0, interrupt_return_op_req = 1'b0;
   logic nested_task_flag = 1'b0, mem_ack = 1'b0;
   logic [63:0] tss_base = B;
   logic [31:0] tss_limit = 32'h0000002c, ip_in = 32'h7a5e1234, flags_in = 32'hc0de0246;
   logic [31:0] mem_rdata = 32'h0;
   logic [GPR_CNT-1:0][31:0] gpr_in;
   logic mem_req, mem_we, mem_wide, busy, done, limit_fault, protection_fault, xfer_ok;
   logic keep_paging, io_map_valid;
   logic [63:0] mem_addr;
   logic [31:0] mem_wdata, ip_out, flags_out;
   logic [15:0] io_map_offset, link_out, ldt_sel_out;
   logic [5:0][15:0] ring_stack_out;
   logic [3:0][15:0] seg_sel_out;
   logic [GPR_CNT-1:0][31:0] gpr_out;
   logic [RSP_CNT-1:0][63:0] privilege_stack_pointers;
   logic [IST_CNT-1:0][63:0] interrupt_stack_pointers;
   int error_cnt = 0, tests_run = 0, cyc = 0;

   tsg_unit tsg_unit_i (.clk(clk), .rst(rst), .mode_64(mode_64), .tss_base(tss_base),
      .tss_limit(tss_limit), .cmd_load16(cmd_load16), .cmd_save16(cmd_save16),
      .cmd_fetch64(cmd_fetch64), .ip_in(ip_in), .flags_in(flags_in), .gpr_in(gpr_in),
      .xfer_req(xfer_req), .xfer_to_task(xfer_to_task), .interrupt_return_op_req(interrupt_return_op_req),
      .nested_task_flag(nested_task_flag), .mem_req(mem_req), .mem_we(mem_we),
      .mem_wide(mem_wide), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .busy(busy), .done(done), .limit_fault(limit_fault),
      .protection_fault(protection_fault), .xfer_ok(xfer_ok), .keep_paging(keep_paging),
      .io_map_valid(io_map_valid), .io_map_offset(io_map_offset), .link_out(link_out),
      .ring_stack_out(ring_stack_out), .ip_out(ip_out), .flags_out(flags_out),
      .gpr_out(gpr_out), .seg_sel_out(seg_sel_out), .ldt_sel_out(ldt_sel_out),
      .privilege_stack_pointers(privilege_stack_pointers),
      .interrupt_stack_pointers(interrupt_stack_pointers));

   always #10 clk = ~clk;

   // ceiling well above the hundred-odd cycles the scenarios need
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         error_cnt = error_cnt + 1;
         test_done();
      end
   end

   task test_done;
      $display("errors %0d of %0d checks", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // memory content tied to address so misplaced fields show up
   function automatic logic [31:0] md(input logic [63:0] a);
      return {~a[15:0], a[15:0] ^ 16'h3c00};
   endfunction : md

   function automatic logic [15:0] lo(input logic [63:0] o);
      logic [31:0] v;
      v = md(B + o);
      return v[15:0];
   endfunction : lo

   function automatic logic [63:0] ofs(input int k, input int i);
      if (k == 0)
         return 64'(2 * i);
      if (k == 1)
         return 64'(14 + 2 * i);
      return (i < 6) ? 64'(4 + 4 * i) : (i < 20) ? 64'(36 + 4 * (i - 6)) : 64'h64;
   endfunction : ofs

   function automatic logic [15:0] sv(input int i);
      return (i == 0) ? ip_in[15:0] : (i == 1) ? flags_in[15:0] : gpr_in[i-2][15:0];
   endfunction : sv

   task automatic cmd(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : cmd

   task automatic serve(input int k, input int n);
      int j;
      for (int i = 0; i < n; i++)
      begin
         j = 0;
         while (mem_req !== 1'b1 && j < 8)
         begin
            @(negedge clk);
            j++;
         end
         chk(mem_addr, B + ofs(k, i));
         chk({mem_we, mem_wide}, {k == 1, k == 2});
         if (k == 1)
            chk(mem_wdata, {16'h0, sv(i)});
         mem_rdata = md(mem_addr);
         mem_ack = 1'b1;
         @(negedge clk);
      end
      // ack stays up between words so it is never driven twice at one edge
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata;
      j = 0;
      while (done !== 1'b1 && j < 4)
      begin
         @(negedge clk);
         j++;
      end
      chk(done, 1'b1);
   endtask : serve

   // back-to-back transfers and returns, result one cycle later
   task automatic t_fault;
      logic [4:0] c [5] = '{5'h1c, 5'h13, 5'h18, 5'h12, 5'h0c};
      logic f;
      for (int q = 0; q <= 5; q++)
      begin
         @(negedge clk);
         if (q > 0)
         begin
            f = (c[q-1][3] & c[q-1][2] | c[q-1][1] & c[q-1][0]) & c[q-1][4];
            chk({protection_fault, xfer_ok}, {f, ~f});
         end
         {mode_64, xfer_req, xfer_to_task, interrupt_return_op_req, nested_task_flag} = (q < 5) ? c[q] : 5'h0;
      end
   endtask : t_fault

   task automatic t_refused;
      @(negedge clk);
      mode_64 = 1'b1;
      cmd(cmd_load16);
      chk(busy, 1'b0);
      mode_64 = 1'b0;
      cmd(cmd_fetch64);
      chk(busy, 1'b0);
   endtask : t_refused

   task automatic t_limit;
      tss_limit = 32'h0000002b;
      cmd(cmd_load16);
      chk({limit_fault, mem_req}, 2'b10);
      tss_limit = 32'h0000002c;
   endtask : t_limit

   task automatic t_load16;
      cmd(cmd_load16); // plain dispatch only, never a virtual-8086 task
      serve(0, 22);
      chk(link_out, lo(0));
      chk(ring_stack_out[5], lo(12));
      chk(ip_out, {16'h0, lo(14)});
      chk(flags_out, {16'h0, lo(16)});
      chk(gpr_out[7], {16'h0, lo(32)});
      chk(seg_sel_out[1], lo(36));
      chk(ldt_sel_out, lo(42));
      chk({keep_paging, io_map_valid}, 2'b10);
      chk(io_map_offset, 16'h0000);
   endtask : t_load16

   task automatic t_fetch64;
      mode_64 = 1'b1;
      cmd(cmd_fetch64);
      serve(2, 21);
      chk(privilege_stack_pointers[0], {md(B + 8), md(B + 4)});
      chk(privilege_stack_pointers[2], {md(B + 24), md(B + 20)});
      chk(interrupt_stack_pointers[0], {md(B + 40), md(B + 36)});
      chk(interrupt_stack_pointers[6], {md(B + 88), md(B + 84)});
      chk(io_map_offset, md(B + 100) >> 16);
      chk({keep_paging, io_map_valid}, 2'b01);
      mode_64 = 1'b0;
   endtask : t_fetch64

   // reset while idle after the last load clears every flag and loaded word
   task automatic t_reset;
      @(negedge clk);
      rst = 1'b1;
      @(negedge clk);
      chk({busy, done, limit_fault, protection_fault, xfer_ok}, 5'h00);
      chk({keep_paging, io_map_valid, link_out}, 18'h0);
      chk(mem_addr, B);
      rst = 1'b0;
      @(negedge clk);
      chk({busy, keep_paging}, 2'b00);
   endtask : t_reset

   initial
   begin
      for (int k = 0; k < GPR_CNT; k++)
         gpr_in[k] = 32'h5c000000 + 32'h00010203 * k;
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_fault();
      t_refused();
      t_limit();
      t_load16();
      cmd(cmd_save16);
      serve(1, 10);
      t_fetch64();
      // a 16-bit dispatch after the 64-bit fetch drops the map again
      t_load16();
      t_reset();
      test_done();
   end
endmodule : test_task_state_segment_handling
